// ### hw/cdd_dma.v
/*
 chained descriptor dma channel: apb registers, descriptor walker,
 byte/word memory master, byte stream to and from a serial channel.
 assumes a memory port that holds mem_ack for one cycle per access
 and serial channel handshakes on the same clock.
*/
`timescale 1ns/10ps
`include "cdd_regs.vh"

// Function
// - descriptor: 16b link, 24b buffer, length, status
// - descriptor fields accessed as single bytes
// - next address is link base over link
// - link field loaded into current descriptor address
// - buffer start copied into buffer address
// - transmit loads length into remaining count
// - tx status bit 7 marks frame end
// - multi-frame tx stops after frame if bit0
// - tx status bits 6 to 1 ignored
// - rx writes stored byte count to length
// - rx status byte bit encoding from channel
// - frame end writes captured frame status
// - mid-frame buffer switch writes zero status
// - byte transfers in cpu mode 1, else words while two or more bytes remain
// - odd buffer start takes one byte first
module cdd_dma (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg mem_req,
  output reg mem_we,
  output reg mem_word,
  output reg [23:0] mem_addr,
  output reg [15:0] mem_wdata,
  input wire [15:0] mem_rdata,
  input wire mem_ack,
  output reg [7:0] tx_data,
  output reg tx_valid,
  output reg tx_last,
  input wire tx_ready,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire rx_eof,
  input wire [7:0] rx_frame_status,
  output reg rx_ready,
  output reg irq
);

  localparam S_IDLE = 3'h0;
  localparam S_FETCH = 3'h1;
  localparam S_XFER = 3'h2;
  localparam S_WB = 3'h3;
  localparam S_LINK = 3'h4;

  ////////////////////////////////////////////////////////////////////
  // registers
  reg [2:0] state_q;
  reg en_q, rx_mode_q, multi_q;
  reg [1:0] cpu_q;
  reg [7:0] link_base_high_q;
  reg [15:0] current_desc_addr_q;
  reg [15:0] rxbuf_len_q;
  reg [23:0] bar_q;
  reg [15:0] remaining_count_q;
  reg [2:0] stat_q, mask_q;
  reg [3:0] idx_q;
  reg [15:0] next_link_low_q;
  reg [23:0] buffer_start_ptr_q;
  reg [15:0] length_field_q;
  reg frame_end_flag_q, stop_after_frame_q;
  reg [7:0] status_wb_q;
  reg frame_done_q;
  reg [15:0] hold_q;
  reg [1:0] hcnt_q;
  reg eof_seen_q;

  wire wide = (cpu_q != `CDD_CPU_BYTE);
  wire [23:0] desc_addr = {link_base_high_q, current_desc_addr_q};
  wire apb_acc = psel & penable & ~pready;
  wire apb_wr = apb_acc & pwrite;
  wire [15:0] rx_room = rxbuf_len_q - remaining_count_q;

  // one function decides every data access width
  function use_word;
    input w;
    input [23:0] a;
    input [15:0] n;
    begin
      use_word = w & ~a[0] & (n >= 16'h0002);
    end
  endfunction

  wire rx_need2 = use_word(wide, bar_q, rx_room);
  wire rx_full = (hcnt_q == (rx_need2 ? 2'h2 : 2'h1));
  wire rx_flush = (hcnt_q != 2'h0) & (rx_full | eof_seen_q);

  reg [2:0] ev;
  always @* begin
    ev = 3'h0;
    if (state_q == S_LINK) begin
      ev[`CDD_INT_SWITCH] = 1'b1;
      ev[`CDD_INT_DONE] = frame_done_q;
    end
    if (state_q == S_XFER && !rx_mode_q && tx_valid && tx_ready &&
        tx_last)
      ev[`CDD_INT_FRAME] = 1'b1;
    if (state_q == S_XFER && rx_mode_q && rx_valid && rx_ready &&
        rx_eof)
      ev[`CDD_INT_FRAME] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, read data registered
  reg [31:0] rd;
  reg hit;
  always @* begin
    rd = 32'h0;
    hit = 1'b1;
    case (paddr)
      `CDD_CTRL: begin
        rd[`CDD_CTRL_EN] = en_q;
        rd[`CDD_CTRL_RX] = rx_mode_q;
        rd[`CDD_CTRL_MULTI] = multi_q;
        rd[`CDD_CTRL_CPU_HI:`CDD_CTRL_CPU_LO] = cpu_q;
        rd[`CDD_CTRL_BUSY] = (state_q != S_IDLE);
      end
      `CDD_LINK_BASE: rd[7:0] = link_base_high_q;
      `CDD_CUR_DESC: rd[15:0] = current_desc_addr_q;
      `CDD_RXBUF_LEN: rd[15:0] = rxbuf_len_q;
      `CDD_BUF_ADDR: rd[23:0] = bar_q;
      `CDD_REM_COUNT: rd[15:0] = remaining_count_q;
      `CDD_INT_STAT: rd[2:0] = stat_q;
      `CDD_INT_MASK: rd[2:0] = mask_q;
      default: hit = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      link_base_high_q <= 8'h00;
      rxbuf_len_q <= `CDD_RXBUF_RST;
      mask_q <= 3'h0;
      stat_q <= 3'h0;
      irq <= 1'b0;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~hit;
      prdata <= (apb_acc & ~pwrite) ? rd : 32'h0;
      // mode values are frozen while the walker runs
      if (apb_wr && paddr == `CDD_LINK_BASE && state_q == S_IDLE)
        link_base_high_q <= pwdata[7:0];
      if (apb_wr && paddr == `CDD_RXBUF_LEN && state_q == S_IDLE)
        rxbuf_len_q <= pwdata[15:0];
      if (apb_wr && paddr == `CDD_INT_MASK)
        mask_q <= pwdata[2:0];
      // set beats a same-cycle write-one clear
      if (apb_wr && paddr == `CDD_INT_STAT)
        stat_q <= (stat_q & ~pwdata[2:0]) | ev;
      else
        stat_q <= stat_q | ev;
      irq <= |((stat_q | ev) & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // descriptor walker and data mover
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      en_q <= 1'b0;
      rx_mode_q <= 1'b0;
      multi_q <= 1'b0;
      cpu_q <= 2'h0;
      current_desc_addr_q <= 16'h0;
      bar_q <= 24'h0;
      remaining_count_q <= 16'h0;
      idx_q <= 4'h0;
      next_link_low_q <= 16'h0;
      buffer_start_ptr_q <= 24'h0;
      length_field_q <= 16'h0;
      frame_end_flag_q <= 1'b0;
      stop_after_frame_q <= 1'b0;
      status_wb_q <= 8'h00;
      frame_done_q <= 1'b0;
      hold_q <= 16'h0;
      hcnt_q <= 2'h0;
      eof_seen_q <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_word <= 1'b0;
      mem_addr <= 24'h0;
      mem_wdata <= 16'h0;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      rx_ready <= 1'b0;
    end else begin
      if (apb_wr && paddr == `CDD_CTRL) begin
        en_q <= pwdata[`CDD_CTRL_EN];
        if (state_q == S_IDLE) begin
          rx_mode_q <= pwdata[`CDD_CTRL_RX];
          multi_q <= pwdata[`CDD_CTRL_MULTI];
          cpu_q <= pwdata[`CDD_CTRL_CPU_HI:`CDD_CTRL_CPU_LO];
        end
      end
      if (apb_wr && paddr == `CDD_CUR_DESC && state_q == S_IDLE)
        current_desc_addr_q <= pwdata[15:0];
      case (state_q)
        S_IDLE: begin
          rx_ready <= 1'b0;
          if (en_q) begin
            state_q <= S_FETCH;
            idx_q <= `CDD_D_LINK_LO;
          end
        end
        // byte-wise descriptor read, pad byte at offset 5 skipped
        S_FETCH: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_word <= 1'b0;
            mem_addr <= desc_addr + {20'h0, idx_q};
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            case (idx_q)
              `CDD_D_LINK_LO: next_link_low_q[7:0] <= mem_rdata[7:0];
              `CDD_D_LINK_HI: next_link_low_q[15:8] <= mem_rdata[7:0];
              `CDD_D_BP0: buffer_start_ptr_q[7:0] <= mem_rdata[7:0];
              `CDD_D_BP1: buffer_start_ptr_q[15:8] <= mem_rdata[7:0];
              `CDD_D_BP2: buffer_start_ptr_q[23:16] <= mem_rdata[7:0];
              `CDD_D_LEN_LO: length_field_q[7:0] <= mem_rdata[7:0];
              `CDD_D_LEN_HI: length_field_q[15:8] <= mem_rdata[7:0];
              default: begin
                // only end-of-frame and stop bits matter on tx
                frame_end_flag_q <= mem_rdata[`CDD_ST_EOM];
                stop_after_frame_q <= mem_rdata[`CDD_ST_EOT];
              end
            endcase
            if (idx_q == `CDD_D_BP2)
              idx_q <= `CDD_D_LEN_LO;
            else
              idx_q <= idx_q + 4'h1;
            // tx reads status and length that the host prepared
            if ((rx_mode_q && idx_q == `CDD_D_BP2) ||
                idx_q == `CDD_D_STAT) begin
              state_q <= S_XFER;
              hcnt_q <= 2'h0;
              eof_seen_q <= 1'b0;
              frame_done_q <= 1'b0;
              bar_q <= (idx_q == `CDD_D_BP2) ?
                {mem_rdata[7:0], buffer_start_ptr_q[15:0]} :
                buffer_start_ptr_q;
              remaining_count_q <= rx_mode_q ? 16'h0 :
                length_field_q;
            end
          end
        end
        S_XFER: begin
          if (!rx_mode_q) begin
            // transmit: refill hold from memory, then stream bytes
            if (tx_valid) begin
              if (tx_ready) begin
                tx_valid <= 1'b0;
                tx_last <= 1'b0;
                hold_q <= {8'h00, hold_q[15:8]};
                hcnt_q <= hcnt_q - 2'h1;
                remaining_count_q <= remaining_count_q - 16'h1;
              end
            end else if (hcnt_q != 2'h0) begin
              tx_valid <= 1'b1;
              tx_data <= hold_q[7:0];
              tx_last <= frame_end_flag_q &&
                remaining_count_q == 16'h1;
            end else if (remaining_count_q == 16'h0) begin
              state_q <= S_LINK;
              frame_done_q <= frame_end_flag_q &&
                (!multi_q || stop_after_frame_q);
            end else if (!mem_req) begin
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              mem_addr <= bar_q;
              mem_word <= use_word(wide, bar_q,
                remaining_count_q);
            end else if (mem_ack) begin
              mem_req <= 1'b0;
              hold_q <= mem_word ? mem_rdata : {8'h00, mem_rdata[7:0]};
              hcnt_q <= mem_word ? 2'h2 : 2'h1;
              bar_q <= bar_q + (mem_word ? 24'h2 : 24'h1);
            end
          end else begin
            // receive: gather bytes, store a byte or a word
            rx_ready <= 1'b0;
            if (rx_valid && rx_ready) begin
              if (hcnt_q == 2'h0)
                hold_q[7:0] <= rx_data;
              else
                hold_q[15:8] <= rx_data;
              hcnt_q <= hcnt_q + 2'h1;
              if (rx_eof) begin
                eof_seen_q <= 1'b1;
                status_wb_q <= rx_frame_status;
              end
            end else if (mem_req) begin
              if (mem_ack) begin
                mem_req <= 1'b0;
                hcnt_q <= 2'h0;
                bar_q <= bar_q + {22'h0, hcnt_q};
                remaining_count_q <= remaining_count_q +
                  {14'h0, hcnt_q};
              end
            end else if (rx_flush) begin
              mem_req <= 1'b1;
              mem_we <= 1'b1;
              mem_addr <= bar_q;
              mem_word <= (hcnt_q == 2'h2);
              mem_wdata <= hold_q;
            end else if (eof_seen_q || rx_room == 16'h0) begin
              // buffer done: length and status go back first
              state_q <= S_WB;
              idx_q <= `CDD_D_LEN_LO;
              if (!eof_seen_q)
                status_wb_q <= 8'h00;
              frame_done_q <= eof_seen_q && !multi_q;
            end else begin
              // an idle offer is dropped for a cycle: never high twice
              rx_ready <= !rx_ready && !rx_full;
            end
          end
        end
        S_WB: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_word <= 1'b0;
            mem_addr <= desc_addr + {20'h0, idx_q};
            case (idx_q)
              `CDD_D_LEN_LO:
                mem_wdata <= {8'h00, remaining_count_q[7:0]};
              `CDD_D_LEN_HI:
                mem_wdata <= {8'h00, remaining_count_q[15:8]};
              default: mem_wdata <= {8'h00, status_wb_q};
            endcase
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            idx_q <= idx_q + 4'h1;
            if (idx_q == `CDD_D_STAT)
              state_q <= S_LINK;
          end
        end
        S_LINK: begin
          current_desc_addr_q <= next_link_low_q;
          idx_q <= `CDD_D_LINK_LO;
          // clearing enable stops the walk at a descriptor boundary
          if (frame_done_q || !en_q) begin
            state_q <= S_IDLE;
            en_q <= 1'b0;
          end else begin
            state_q <= S_FETCH;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

endmodule // cdd_dma

// ### hw/cdd_regs.vh
/*
 chained descriptor dma: register offsets, fields, layout constants.
 assumes byte addresses on a 32-bit apb; definitions only.
*/
`ifndef CDD_REGS_VH
`define CDD_REGS_VH
`define CDD_CTRL 8'h00
`define CDD_LINK_BASE 8'h04
`define CDD_CUR_DESC 8'h08
`define CDD_RXBUF_LEN 8'h0C
`define CDD_BUF_ADDR 8'h10
`define CDD_REM_COUNT 8'h14
`define CDD_INT_STAT 8'h18
`define CDD_INT_MASK 8'h1C
`define CDD_CTRL_EN 0
`define CDD_CTRL_RX 1
`define CDD_CTRL_MULTI 2
`define CDD_CTRL_CPU_LO 4
`define CDD_CTRL_CPU_HI 5
`define CDD_CTRL_BUSY 8
`define CDD_CPU_BYTE 2'h1
`define CDD_INT_DONE 0
`define CDD_INT_FRAME 1
`define CDD_INT_SWITCH 2
`define CDD_RXBUF_RST 16'h0100
`define CDD_D_LINK_LO 4'h0
`define CDD_D_LINK_HI 4'h1
`define CDD_D_BP0 4'h2
`define CDD_D_BP1 4'h3
`define CDD_D_BP2 4'h4
`define CDD_D_LEN_LO 4'h6
`define CDD_D_LEN_HI 4'h7
`define CDD_D_STAT 4'h8
`define CDD_ST_EOM 7
`define CDD_ST_EOT 0
`endif

// ### sim/cdd_dma_assertions.sv
/* port checker for the chained descriptor dma.
 assumes one clock and an apb master that releases after pready. */
`timescale 1ns/10ps
`include "cdd_regs.vh"
module cdd_dma_assertions (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire mem_req,
  input wire mem_we,
  input wire mem_word,
  input wire [23:0] mem_addr,
  input wire mem_ack,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_last,
  input wire tx_ready,
  input wire rx_valid,
  input wire rx_eof,
  input wire rx_ready,
  input wire irq
);
  // mode as last written, idle or busy; it matches the core only while ctrl is written when idle
  logic [1:0] mode_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mode_q <= 2'h0;
    else if (psel && penable && pwrite && !pready && paddr == `CDD_CTRL)
      mode_q <= pwdata[5:4];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req &&
    $stable(mem_addr) && $stable(mem_we) && $stable(mem_word))
    else $error("memory request changed before ack");
  mem_gap_a: assert property (mem_ack |=> !mem_req)
    else $error("memory request held past ack");
  odd_word_a: assert property (mem_req && mem_word |->
    !mem_addr[0])
    else $error("word access at odd address");
  byte_mode_a: assert property (mem_req &&
    mode_q == `CDD_CPU_BYTE |-> !mem_word)
    else $error("word access in byte cpu mode");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid &&
    $stable(tx_data) && $stable(tx_last))
    else $error("tx byte changed before taken");
  rx_gap_a: assert property (rx_ready |=> !rx_ready)
    else $error("rx_ready high two cycles");
  cover property (tx_valid && tx_ready && tx_last);
  cover property (rx_valid && rx_ready && rx_eof);
  cover property ($rose(irq));
endmodule // cdd_dma_assertions

bind cdd_dma cdd_dma_assertions u_cdd_dma_assertions (.*);

// ### sim/cdd_far_model.sv
/* far side: byte memory, stalling tx sink, framed rx source.
 assumes the dma memory port and byte streams run on pclk. */
`timescale 1ns/10ps
module cdd_far_model #(
  parameter logic [7:0] HI = 8'h5A
) (
  input wire pclk,
  input wire mem_req,
  input wire mem_we,
  input wire mem_word,
  input wire [23:0] mem_addr,
  input wire [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_last,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_eof,
  output logic [7:0] rx_frame_status,
  input wire rx_ready
);
  logic [7:0] mem [0:8191];
  logic [8:0] tx_q [$];
  logic [1:0] cyc = 2'h0;
  wire [12:0] a = mem_addr[12:0];
  int words = 0;
  int bad = 0;
  initial begin
    {mem_rdata, mem_ack, tx_ready, rx_data, rx_valid, rx_eof} = '0;
    rx_frame_status = 8'h00;
  end
  ////////////////////////////////////////
  // acks only on odd cycles so both quick and slow answers occur
  always @(posedge pclk) begin
    cyc <= cyc + 2'h1;
    tx_ready <= cyc[1];
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata; // idle bus never repeats old data
    if (tx_valid && tx_ready)
      tx_q.push_back({tx_last, tx_data});
    if (mem_req && !mem_ack && cyc[0]) begin
      mem_ack <= 1'b1;
      if (mem_addr[23:16] !== HI)
        bad <= bad + 1;
      if (mem_word)
        words <= words + 1;
      if (mem_we) begin
        mem[a] <= mem_wdata[7:0];
        if (mem_word)
          mem[a + 13'h1] <= mem_wdata[15:8];
      end else
        mem_rdata <= {mem[a + 13'h1], mem[a]};
    end
  end
  // one bit-synchronous frame, status given with the last byte
  task automatic send_rx(input int n, input logic [7:0] st);
    @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_data <= 8'h40 + i[7:0];
      rx_eof <= (i == n - 1);
      rx_frame_status <= st;
      do @(posedge pclk); while (!rx_ready);
    end
    rx_valid <= 1'b0;
    rx_eof <= 1'b0;
    rx_data <= ~rx_data;
    rx_frame_status <= ~st;
  endtask
endmodule // cdd_far_model

// ### sim/tb_chained_descriptor_dma.sv
/* self-checking bench: apb setup, chained tx and rx runs.
 assumes the far-side model holds memory and the serial streams. */
`timescale 1ns/10ps
`include "cdd_regs.vh"
module tb_chained_descriptor_dma;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire [23:0] mem_addr;
  wire [15:0] mem_wdata, mem_rdata;
  wire [7:0] tx_data, rx_data, rx_frame_status;
  wire pready, pslverr, mem_req, mem_we, mem_word, mem_ack, tx_valid;
  wire tx_last, tx_ready, rx_valid, rx_eof, rx_ready, irq;
  int num_errors = 0;
  int total_checks = 0;
  cdd_dma u_cdd_dma (.*);
  cdd_far_model u_cdd_far_model (.*);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // descriptor laid out by the host before use
  task automatic desc(input logic [12:0] a, input logic [15:0] lk,
      input logic [23:0] bp, input logic [15:0] len, input logic [7:0] st);
    logic [71:0] f;
    f = {st, len, 8'h00, bp, lk};
    for (int i = 0; i < 9; i++)
      u_cdd_far_model.mem[a + i] = f[8*i +: 8];
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, `CDD_CTRL, 32'h0);
      k++;
    end while ((rd[8] | rd[0]) !== 1'b0 && k < 300);
    chk(rd[8] | rd[0], 1'b0);
  endtask
  function automatic logic [23:0] tail(input logic [12:0] a);
    return {u_cdd_far_model.mem[a + 2], u_cdd_far_model.mem[a + 1],
      u_cdd_far_model.mem[a]};
  endfunction
  task conclude;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    $display("unexpected %0t: run did not finish", $time);
    conclude();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, err, rd} = '0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk({mem_req, tx_valid, rx_ready, irq, pready}, 32'h0);
    apb(1'b0, `CDD_RXBUF_LEN, 32'h0);
    chk(rd, 32'h100);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // tx: odd start in word mode, ignored bits, stop flag honoured
    for (int i = 0; i < 5; i++)
      u_cdd_far_model.mem[13'h201 + i] = 8'h11 + i[7:0];
    for (int i = 0; i < 3; i++)
      u_cdd_far_model.mem[13'h300 + i] = 8'h21 + i[7:0];
    desc(13'h100, 16'h0120, 24'h5A0201, 16'h0005, 8'h7E);
    desc(13'h120, 16'h0140, 24'h5A0300, 16'h0003, 8'h81);
    desc(13'h140, 16'h0100, 24'h5A0300, 16'h0001, 8'h81);
    apb(1'b1, `CDD_LINK_BASE, 32'h5A);
    apb(1'b1, `CDD_CUR_DESC, 32'h100);
    apb(1'b1, `CDD_CTRL, 32'h5);
    wait_idle();
    chk(u_cdd_far_model.tx_q.size(), 32'h8);
    for (int i = 0; i < 8; i++)
      chk(u_cdd_far_model.tx_q[i], i < 5 ? 9'h011 + i :
        (i == 7 ? 9'h123 : 9'h01C + i));
    chk(u_cdd_far_model.words != 0, 1'b1);
    apb(1'b0, `CDD_REM_COUNT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `CDD_INT_STAT, 32'h0);
    chk(rd, 32'h7);
    chk(irq, 1'b0);
    apb(1'b1, `CDD_INT_MASK, 32'h1);
    #1 chk(irq, 1'b1);
    apb(1'b1, `CDD_INT_STAT, 32'h7);
    #1 chk(irq, 1'b0);
    // rx: byte mode, one frame split over two four-byte buffers
    u_cdd_far_model.words = 0;
    desc(13'h180, 16'h01A0, 24'h5A0400, 16'h0000, 8'h55);
    desc(13'h1A0, 16'h01C0, 24'h5A0501, 16'h0000, 8'h55);
    apb(1'b1, `CDD_RXBUF_LEN, 32'h4);
    apb(1'b1, `CDD_CUR_DESC, 32'h180);
    apb(1'b1, `CDD_CTRL, 32'h13);
    u_cdd_far_model.send_rx(6, 8'h8C);
    wait_idle();
    for (int i = 0; i < 6; i++)
      chk(u_cdd_far_model.mem[(i < 4 ? 13'h400 : 13'h4FD) + i],
        8'h40 + i[7:0]);
    chk(tail(13'h186), 24'h000004);
    chk(tail(13'h1A6), 24'h8C0002);
    chk(u_cdd_far_model.words, 32'h0);
    // rx: word mode, odd start, one four-byte frame in one buffer
    u_cdd_far_model.words = 0;
    desc(13'h1C0, 16'h0180, 24'h5A0601, 16'h0000, 8'h55);
    apb(1'b1, `CDD_RXBUF_LEN, 32'h8);
    apb(1'b1, `CDD_CUR_DESC, 32'h1C0);
    apb(1'b1, `CDD_CTRL, 32'h3);
    u_cdd_far_model.send_rx(4, 8'h84);
    wait_idle();
    for (int i = 0; i < 4; i++)
      chk(u_cdd_far_model.mem[13'h601 + i], 8'h40 + i[7:0]);
    chk(tail(13'h1C6), 24'h840004);
    chk(u_cdd_far_model.words, 32'h1);
    chk(u_cdd_far_model.bad, 32'h0);
    conclude();
  end
endmodule // tb_chained_descriptor_dma
